/* File: hdl/two_port_pin_config_io.sv */
// Purpose: Two configurable GPIO ports behind an APB register slave.
// Assumes: Pad inputs synchronous to pclk; boot options steady at reset.
// Notes:   Pad drive is registered from next configuration values.
//
// Local design decision: the APB interface to the registers.
module two_port_pin_config_io
    import pincfg_pkg::*;
(
    input  wire logic              pclk,           // System clock
    input  wire logic              presetn,        // Async reset, low
    input  wire logic              psel,           // APB select
    input  wire logic              penable,        // APB access phase
    input  wire logic              pwrite,         // APB direction
    input  wire logic [ADDR_W-1:0] paddr,          // APB address
    input  wire logic [DATA_W-1:0] pwdata,         // APB write data
    output logic [DATA_W-1:0]      prdata,         // APB read data
    output logic                   pready,         // APB ready
    output logic                   pslverr,        // APB error
    input  wire logic              opt_osc_en,     // Boot option: osc
    input  wire logic              opt_rst_en,     // Boot option: reset
    input  wire logic [PB_W-1:0]   pb_in,          // First port pads
    output logic [PB_W-1:0]        pb_out,         // First port out
    output logic [PB_W-1:0]        pb_oe,          // First port enable
    output logic [PB_W-1:0]        pb_pull_up,     // First port pull-up
    output logic [PB_W-1:0]        pb_pull_down,   // First port pull-down
    output logic                   osc_pins_sel,   // Pins 0,1 to osc
    output logic                   ext_reset_sel,  // Pin 2 to reset
    output logic                   ext_reset_n,    // Reset pin level
    input  wire logic              sys_clk_src,    // Clock to output
    input  wire logic              timer_src,      // Timer out level
    input  wire logic [PC_W-1:0]   pc_in,          // Second port pads
    output logic [PC_W-1:0]        pc_out,         // Second port out
    output logic [PC_W-1:0]        pc_oe,          // Second port enable
    output logic [PC_W-1:0]        pc_pull_up,     // Second port pull-up
    output logic [PC_W-1:0]        pc_analog_sel   // Analog input select
);
    import pincfg_pkg::*;

    // Whole block state
    typedef struct packed {
        logic [REG_W-1:0]  pb_cfg;      // port_b_config
        logic [REG_W-1:0]  pc_cfgh;     // port_c_config_high
        logic [REG_W-1:0]  pc_cfgl;     // port_c_config_low
        logic [PC_W-1:0]   pc_pu;       // port_c_pull_up
        logic [PB_W-1:0]   pb_lat;      // First port latches
        logic [PC_W-1:0]   pc_lat;      // Second port latches
        logic              opt_done;    // Options captured
        logic              osc_sel;     // Oscillator option
        logic              rst_sel;     // Reset pin option
        logic              rst_n;       // Reset pin level
        logic [PB_W-1:0]   pb_out;
        logic [PB_W-1:0]   pb_oe;
        logic [PB_W-1:0]   pb_pu;
        logic [PB_W-1:0]   pb_pd;
        logic [PC_W-1:0]   pc_out;
        logic [PC_W-1:0]   pc_oe;
        logic [PC_W-1:0]   pc_pull;
        logic [PC_W-1:0]   pc_ana;
        logic [DATA_W-1:0] rdata;
        logic              ready;
        logic              err;
    } state_t;

    state_t st_r;                       // Registered state
    state_t st_nxt;                     // Next state

    logic [SEL_W-1:0]  sel;             // Register select
    logic              hit;             // Mapped address
    logic              setup;           // APB setup cycle
    logic              wr_done;         // Write commits this edge
    logic [2*PC_W-1:0] pc_mode_bits;    // Second port modes, packed
    logic [PB_W-1:0]   pb_nout;         // Next pad values, first port
    logic [PB_W-1:0]   pb_noe;
    logic [PC_W-1:0]   pc_nout;         // Next pad values, second port
    logic [PC_W-1:0]   pc_noe;
    logic [PC_W-1:0]   pc_alt_drv;      // Alternate drives the pad
    logic [PC_W-1:0]   pc_alt_val;      // Alternate output level
    logic [PB_W-1:0]   pb_rd;           // First port read view
    logic [PC_W-1:0]   pc_rd;           // Second port read view

    // Address decode
    reg_decode u_dec (
        .paddr (paddr),
        .sel   (sel),
        .hit   (hit)
    );

    assign setup   = psel & ~penable;
    assign wr_done = psel & penable & st_r.ready & pwrite & hit;

    // Second port mode fields from next config
    assign pc_mode_bits = {st_nxt.pc_cfgh[2*(PC_W-PC_LOW_PINS)-1:0],
                           st_nxt.pc_cfgl};

    // Alternate outputs: clock and timer pins drive, analog pins float
    always_comb begin
        pc_alt_drv             = '0;
        pc_alt_val             = '0;
        pc_alt_drv[PC_CLK_PIN] = 1'b1;
        pc_alt_val[PC_CLK_PIN] = sys_clk_src;
        pc_alt_drv[PC_TMR_PIN] = 1'b1;
        pc_alt_val[PC_TMR_PIN] = timer_src;
    end

    // Per-pin drive, first port; no alternate output
    genvar gb;
    generate
        for (gb = 0; gb < PB_W; gb++) begin : g_pb
            pin_cell u_cell (
                .mode      (pin_mode_t'(st_nxt.pb_cfg[2*gb+:2])),
                .latch     (st_nxt.pb_lat[gb]),
                .alt_drive (1'b0),
                .alt_val   (1'b0),
                .pin_out   (pb_nout[gb]),
                .pin_oe    (pb_noe[gb])
            );
        end
    endgenerate

    // Per-pin drive, second port
    genvar gc;
    generate
        for (gc = 0; gc < PC_W; gc++) begin : g_pc
            pin_cell u_cell (
                .mode      (pin_mode_t'(pc_mode_bits[2*gc+:2])),
                .latch     (st_nxt.pc_lat[gc]),
                .alt_drive (pc_alt_drv[gc]),
                .alt_val   (pc_alt_val[gc]),
                .pin_out   (pc_nout[gc]),
                .pin_oe    (pc_noe[gc])
            );
        end
    endgenerate

    // Read view: pad levels, zero on oscillator, reset and analog pins; clock and timer pins read the pad
    always_comb begin
        pb_rd = pb_in;
        if (st_r.osc_sel) begin
            pb_rd[1:0] = 2'h0;
        end
        if (st_r.rst_sel) begin
            pb_rd[PB_RST_PIN] = 1'b0;
        end
        pc_rd = pc_in & ~st_r.pc_ana;
    end

    // Next-state logic: APB, registers, pad drive
    always_comb begin
        st_nxt = st_r;
        // Boot options caught once, first edge after reset release
        if (!st_r.opt_done) begin
            st_nxt.opt_done = 1'b1;
            st_nxt.osc_sel  = opt_osc_en;
            st_nxt.rst_sel  = opt_rst_en;
        end
        // Reset pin level follows pad while selected
        st_nxt.rst_n = st_r.rst_sel ? pb_in[PB_RST_PIN] : 1'b1;

        // APB: answer prepared in setup, one access cycle
        if (setup) begin
            st_nxt.ready = 1'b1;
            st_nxt.err   = ~hit;
            st_nxt.rdata = '0;
            if (!pwrite) begin
                unique case (1'b1)
                    sel[S_PB_DATA]: st_nxt.rdata[PB_W-1:0]  = pb_rd;
                    sel[S_PC_DATA]: st_nxt.rdata[PC_W-1:0]  = pc_rd;
                    sel[S_PB_CFG]:  st_nxt.rdata[REG_W-1:0] = st_r.pb_cfg;
                    sel[S_PC_CFGH]: st_nxt.rdata[REG_W-1:0] = st_r.pc_cfgh;
                    sel[S_PC_CFGL]: st_nxt.rdata[REG_W-1:0] = st_r.pc_cfgl;
                    sel[S_PC_PULL]: st_nxt.rdata[PC_W-1:0]  = st_r.pc_pu;
                    default:        st_nxt.rdata = '0;        // Unmapped
                endcase
            end
        end else if (psel && penable && st_r.ready) begin
            st_nxt.ready = 1'b0;                              // Done
            st_nxt.err   = 1'b0;
        end

        // Register writes commit at the access edge
        if (wr_done) begin
            if (sel[S_PB_DATA]) begin
                st_nxt.pb_lat = pwdata[PB_W-1:0];
            end
            if (sel[S_PC_DATA]) begin
                st_nxt.pc_lat = pwdata[PC_W-1:0];
            end
            if (sel[S_PB_CFG]) begin
                st_nxt.pb_cfg = pwdata[REG_W-1:0];
            end
            if (sel[S_PC_CFGH]) begin
                st_nxt.pc_cfgh = pwdata[REG_W-1:0] & PC_CFGH_MASK;
            end
            if (sel[S_PC_CFGL]) begin
                st_nxt.pc_cfgl = pwdata[REG_W-1:0];
            end
            if (sel[S_PC_PULL]) begin
                st_nxt.pc_pu = pwdata[PC_W-1:0];
            end
        end

        // First port pad drive and pulls, from next config
        st_nxt.pb_out = pb_nout;
        st_nxt.pb_oe  = pb_noe;
        for (int i = 0; i < PB_W; i++) begin
            // Pulled input: direction chosen by shared bit
            if (pin_mode_t'(st_nxt.pb_cfg[2*i+:2]) == MODE_SPEC) begin
                st_nxt.pb_pu[i] = ~st_nxt.pb_cfg[PB_PULL_DN_BIT];
                st_nxt.pb_pd[i] = st_nxt.pb_cfg[PB_PULL_DN_BIT];
            end else begin
                st_nxt.pb_pu[i] = st_nxt.pb_cfg[PB_OD_PU_BIT] &
                    (pin_mode_t'(st_nxt.pb_cfg[2*i+:2]) == MODE_OD);
                st_nxt.pb_pd[i] = 1'b0;
            end
        end
        // Oscillator and reset functions take their pins off the port
        if (st_nxt.osc_sel) begin
            st_nxt.pb_oe[1:0] = 2'h0;
            st_nxt.pb_pu[1:0] = 2'h0;
            st_nxt.pb_pd[1:0] = 2'h0;
        end
        if (st_nxt.rst_sel) begin
            st_nxt.pb_oe[PB_RST_PIN] = 1'b0;
            st_nxt.pb_pd[PB_RST_PIN] = 1'b0;
            st_nxt.pb_pu[PB_RST_PIN] = 1'b1;                  // Idle high
        end

        // Second port pads; analog pins lose drive and pull
        st_nxt.pc_out = pc_nout;
        st_nxt.pc_oe  = pc_noe;
        for (int j = 0; j < PC_W; j++) begin
            st_nxt.pc_ana[j] = PC_ANALOG[j] &
                (pin_mode_t'(pc_mode_bits[2*j+:2]) == MODE_SPEC);
        end
        st_nxt.pc_pull = st_nxt.pc_pu & ~st_nxt.pc_ana;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r         <= '0;
            st_r.pb_cfg  <= RST_REG;
            st_r.pc_cfgh <= RST_REG;
            st_r.pc_cfgl <= RST_REG;
            st_r.rst_n   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state
    assign prdata        = st_r.rdata;
    assign pready        = st_r.ready;
    assign pslverr       = st_r.err;
    assign pb_out        = st_r.pb_out;
    assign pb_oe         = st_r.pb_oe;
    assign pb_pull_up    = st_r.pb_pu;
    assign pb_pull_down  = st_r.pb_pd;
    assign osc_pins_sel  = st_r.osc_sel;
    assign ext_reset_sel = st_r.rst_sel;
    assign ext_reset_n   = st_r.rst_n;
    assign pc_out        = st_r.pc_out;
    assign pc_oe         = st_r.pc_oe;
    assign pc_pull_up    = st_r.pc_pull;
    assign pc_analog_sel = st_r.pc_ana;

    logic [REG_W-1:0] pb_cfg_q;         // Config view for checks
    assign pb_cfg_q = st_r.pb_cfg;

    // Checks next to the logic
    a_pb_cfg_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_done && sel[S_PB_CFG] |=> pb_cfg_q == $past(pwdata[7:0]))
        else $error("first port config not stored");

    a_pb_data_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_done && sel[S_PB_DATA] ##1 (pb_cfg_q[1:0] == MODE_PP)
        |-> pb_out[0] == $past(pwdata[0]))
        else $error("first port latch not driven");

    a_pb_push_pull: assert property (@(posedge pclk)
        disable iff (!presetn)
        (pb_cfg_q[5:4] == MODE_PP) && !st_r.rst_sel |-> pb_oe[2])
        else $error("push-pull pin not driven");

    a_pb_open_drain: assert property (@(posedge pclk)
        disable iff (!presetn)
        pb_oe[2] && (pb_cfg_q[5:4] == MODE_OD) |-> !pb_out[2])
        else $error("open-drain pin drove high");

    a_osc_pins_free: assert property (@(posedge pclk)
        disable iff (!presetn)
        osc_pins_sel |-> pb_oe[1:0] == 2'h0)
        else $error("oscillator pin driven");

    a_reset_pin_free: assert property (@(posedge pclk)
        disable iff (!presetn)
        ext_reset_sel |=> !pb_oe[PB_RST_PIN] &&
        ext_reset_n == $past(pb_in[2]))
        else $error("reset pin misrouted");

    a_pc_cfg_split: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_done && sel[S_PC_CFGH] |=> st_r.pc_cfgh[7:6] == 2'h0 &&
        st_r.pc_cfgh[5:0] == $past(pwdata[5:0]))
        else $error("second port high config wrong");

    a_pc_analog_off: assert property (@(posedge pclk)
        disable iff (!presetn)
        pc_analog_sel[0] |-> !pc_oe[0] && !pc_pull_up[0])
        else $error("analog pin still driven");

    a_apb_one_wait: assert property (@(posedge pclk)
        disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
endmodule

/* File: hdl/pincfg_pkg.sv */
// Purpose: Shared constants for the two-port pin configuration block.
// Assumes: APB byte address is four times the register index.
// Notes:   Two configuration bits per pin; encodings below.
// Behaviour
// - First port has three independent pins
// - First port: Schmitt input, push-pull, open-drain
// - First port pins may enable pull-up or pull-down
// - Oscillator option takes first port pins 0, 1
// - Reset option takes first port pin 2
// - One register configures the whole first port
// - First port data: read pins, write latches
// - Second port has seven independent pins
// - Second port: Schmitt input, push-pull, open-drain
// - Second port alternates: analog, clock, timer out
// - Second port pins may enable pull-up
// - Second port data register reads and writes
// - Second port configuration split high and low
package pincfg_pkg;
    // Widths
    localparam int PB_W   = 3;                 // First port pins
    localparam int PC_W   = 7;                 // Second port pins
    localparam int ADDR_W = 12;                // APB address width
    localparam int DATA_W = 32;                // APB data width
    localparam int REG_W  = 8;                 // Register width

    // Register indices, byte address = index * 4
    localparam logic [9:0] IDX_PB_DATA = 10'h0E1; // port_b_data
    localparam logic [9:0] IDX_PC_DATA = 10'h0E2; // port_c_data
    localparam logic [9:0] IDX_PB_CFG  = 10'h0E9; // port_b_config
    localparam logic [9:0] IDX_PC_CFGH = 10'h0EA; // port_c_config_high
    localparam logic [9:0] IDX_PC_CFGL = 10'h0EB; // port_c_config_low
    localparam logic [9:0] IDX_PC_PULL = 10'h0EC; // port_c_pull_up

    // Register select, one-hot
    localparam int SEL_W = 6;
    localparam int S_PB_DATA = 0;
    localparam int S_PC_DATA = 1;
    localparam int S_PB_CFG  = 2;
    localparam int S_PC_CFGH = 3;
    localparam int S_PC_CFGL = 4;
    localparam int S_PC_PULL = 5;

    // Pin mode field, two bits per pin
    typedef enum logic [1:0] {
        MODE_IN   = 2'h0,   // Schmitt trigger input
        MODE_OD   = 2'h1,   // N-channel open-drain output
        MODE_PP   = 2'h2,   // Push-pull output
        MODE_SPEC = 2'h3    // First port: pulled input; second: alternate
    } pin_mode_t;

    // First port config fields
    localparam int PB_PULL_DN_BIT = 7;  // 1: pulled inputs pull down
    localparam int PB_OD_PU_BIT   = 6;  // Pull-up on open-drain pins
    // Second port: pins 0..3 in low byte, 4..6 in high byte
    localparam int PC_LOW_PINS    = 4;
    localparam logic [REG_W-1:0] PC_CFGH_MASK = 8'h3F; // Upper bits zero
    localparam logic [PC_W-1:0]  PC_ANALOG    = 7'h1F; // Pins 0..4
    localparam int PC_CLK_PIN   = 5;    // system_clock_out pin
    localparam int PC_TMR_PIN   = 6;    // timer_clock_out pin
    localparam int PB_RST_PIN   = 2;    // External reset pin

    // Reset values
    localparam logic [REG_W-1:0] RST_REG = 8'h00;
endpackage

/* File: hdl/pin_cell.sv */
// Purpose: Drive decode of one pin from its mode and data latch.
// Assumes: Alternate drive is already a registered level.
// Notes:   Purely combinational; the top registers the results.
module pin_cell
    import pincfg_pkg::*;
(
    input  wire pin_mode_t mode,       // Configured mode
    input  wire logic      latch,      // Output data latch
    input  wire logic      alt_drive,  // Alternate mode drives pin
    input  wire logic      alt_val,    // Alternate output level
    output logic           pin_out,    // Pad output value
    output logic           pin_oe      // Pad output enable
);
    // Mode to pad drive
    always_comb begin
        pin_out = 1'b0;
        pin_oe  = 1'b0;
        unique case (mode)
            MODE_IN: begin               // Pad left to the outside
                pin_oe = 1'b0;
            end
            MODE_OD: begin               // Only ever pulls low
                pin_out = 1'b0;
                pin_oe  = ~latch;
            end
            MODE_PP: begin               // Drives both levels
                pin_out = latch;
                pin_oe  = 1'b1;
            end
            MODE_SPEC: begin             // Alternate function if any
                pin_out = alt_val;
                pin_oe  = alt_drive;
            end
        endcase
    end
endmodule

/* File: hdl/reg_decode.sv */
// Purpose: APB address decode to a one-hot register select.
// Assumes: Word-aligned accesses; low two address bits must be zero.
// Notes:   Unmapped or misaligned addresses give an empty select.
module reg_decode
    import pincfg_pkg::*;
(
    input  wire logic [ADDR_W-1:0] paddr,   // APB byte address
    output logic [SEL_W-1:0]       sel,     // One-hot select
    output logic                   hit      // Some register selected
);
    logic [9:0] idx;                        // Word index

    // Index compare
    always_comb begin
        idx = paddr[ADDR_W-1:2];
        sel = '0;
        if (paddr[1:0] == 2'h0) begin
            sel[S_PB_DATA] = (idx == IDX_PB_DATA);
            sel[S_PC_DATA] = (idx == IDX_PC_DATA);
            sel[S_PB_CFG]  = (idx == IDX_PB_CFG);
            sel[S_PC_CFGH] = (idx == IDX_PC_CFGH);
            sel[S_PC_CFGL] = (idx == IDX_PC_CFGL);
            sel[S_PC_PULL] = (idx == IDX_PC_PULL);
        end
        hit = |sel;
    end
endmodule

/* File: sim/pad_board.sv */
// Purpose: Board model that resolves the pad levels of both ports.
// Assumes: Own drive wins, then a board source, then the pulls.
// Notes:   A floating pad toggles every cycle, so it is never trusted.
module pad_board
    import pincfg_pkg::*;
(
    input  wire logic            pclk,       // System clock
    input  wire logic [PB_W-1:0] pb_out,     // First port drive value
    input  wire logic [PB_W-1:0] pb_oe,      // First port drive enable
    input  wire logic [PB_W-1:0] pb_pu,      // First port pull-up
    input  wire logic [PB_W-1:0] pb_pd,      // First port pull-down
    input  wire logic [PB_W-1:0] pb_src_en,  // Board drives first port
    input  wire logic [PB_W-1:0] pb_src,     // Board level, first port
    input  wire logic [PC_W-1:0] pc_out,     // Second port drive value
    input  wire logic [PC_W-1:0] pc_oe,      // Second port drive enable
    input  wire logic [PC_W-1:0] pc_pu,      // Second port pull-up
    input  wire logic [PC_W-1:0] pc_src_en,  // Board drives second port
    input  wire logic [PC_W-1:0] pc_src,     // Board level, second port
    output logic      [PB_W-1:0] pb_in,      // First port pad level
    output logic      [PC_W-1:0] pc_in       // Second port pad level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic flt_r = 1'b0;  // Floating pad pattern

    // One pad: drive, board source, pull-up, pull-down, else noise
    function automatic logic pad(input logic oe, input logic o,
                                 input logic en, input logic v,
                                 input logic pu, input logic pd,
                                 input logic f);
        if (oe) begin
            return o;
        end
        if (en) begin
            return v;
        end
        if (pu) begin
            return 1'b1;
        end
        if (pd) begin
            return 1'b0;
        end
        return f;
    endfunction

    // Pattern flips so a missing pull is seen, not settled by chance
    always_ff @(posedge pclk) begin
        flt_r <= ~flt_r;
    end

    // Resolve every pad from all parties on it
    always_comb begin
        for (int i = 0; i < PB_W; i++) begin
            pb_in[i] = pad(pb_oe[i], pb_out[i], pb_src_en[i], pb_src[i],
                           pb_pu[i], pb_pd[i], flt_r ^ i[0]);
        end
        for (int i = 0; i < PC_W; i++) begin
            pc_in[i] = pad(pc_oe[i], pc_out[i], pc_src_en[i], pc_src[i],
                           pc_pu[i], 1'b0, flt_r ^ i[0]);
        end
    end
endmodule

/* File: sim/two_port_pin_config_io_tb.sv */
// Purpose: Self-checking bench for the two-port pin block over APB.
// Assumes: One access phase per transfer, waited for under a bound.
// Notes:   Pad levels come from the board model, never from outputs.
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin \
    bad_count++; $display("BAD %0t %s", $time, m); end end
module two_port_pin_config_io_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pincfg_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, opt_osc_en = 1'b0, opt_rst_en = 1'b0;
    logic sys_clk_src = 1'b1, timer_src = 1'b0, pready, pslverr;
    logic osc_pins_sel, ext_reset_sel, ext_reset_n;
    logic [ADDR_W-1:0] paddr = '0;            // APB address
    logic [DATA_W-1:0] pwdata = '0, prdata;   // APB data
    logic [PB_W-1:0] pb_in, pb_out, pb_oe, pb_pull_up, pb_pull_down;
    logic [PB_W-1:0] pb_src_en = '1, pb_src = 3'h6;  // Board, first port
    logic [PC_W-1:0] pc_in, pc_out, pc_oe, pc_pull_up, pc_analog_sel;
    logic [PC_W-1:0] pc_src_en = '1, pc_src = 7'h2A; // Board, second port
    logic [DATA_W-1:0] rd_v;                  // Last read data
    logic err_v;                              // Last error flag
    int bad_count = 0, cmp_count = 0;
    // Table: config, pad enable, pad value, pull-up, pull-down
    logic [7:0] tb_cfg [6] = '{8'h2A, 8'h15, 8'h55, 8'h3F, 8'hBF, 8'h06};
    logic [PB_W-1:0] tb_oe [6] = '{3'h7, 3'h6, 3'h6, 3'h0, 3'h0, 3'h3};
    logic [PB_W-1:0] tb_out [6] = '{3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1};
    logic [PB_W-1:0] tb_pu [6] = '{3'h0, 3'h0, 3'h7, 3'h7, 3'h0, 3'h0};
    logic [PB_W-1:0] tb_pd [6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h0};

    // Bus clock, 100 ns period
    always #50 pclk = ~pclk;

    two_port_pin_config_io two_port_pin_config_io_i (.*);
    pad_board pad_board_i (.pclk(pclk), .pb_out(pb_out), .pb_oe(pb_oe),
        .pb_pu(pb_pull_up), .pb_pd(pb_pull_down), .pb_src_en(pb_src_en),
        .pb_src(pb_src), .pc_out(pc_out), .pc_oe(pc_oe),
        .pc_pu(pc_pull_up), .pc_src_en(pc_src_en), .pc_src(pc_src),
        .pb_in(pb_in), .pc_in(pc_in));

    // Counts, then the one verdict of the run
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One APB transfer; the wait for pready is bounded
    task automatic apb(input logic [9:0] idx, input logic wr,
                       input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // Looked at mid-cycle: what the next rising edge will sample
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("BAD %0t no ready", $time);
            print_verdict();
        end
        rd_v = prdata;
        err_v = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write, then look at the pads once the commit edge has landed
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(idx, 1'b1, d);
        @(negedge pclk);
        `CHK(err_v, 1'b0, "write refused")
    endtask

    // Read and compare a whole word
    task automatic rd(input logic [9:0] idx, input logic [31:0] e);
        apb(idx, 1'b0, 8'h00);
        `CHK(rd_v, e, "read data")
        `CHK(err_v, 1'b0, "read refused")
    endtask

    // Reset held for eight cycles with the given boot options
    task automatic do_reset(input logic osc, input logic rst);
        presetn <= 1'b0;
        opt_osc_en <= osc;
        opt_rst_en <= rst;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
    endtask

    initial begin
        do_reset(1'b0, 1'b0);
        // Reset values, pins read through the data registers
        rd(IDX_PB_DATA, 32'h6);
        rd(IDX_PC_DATA, 32'h2A);
        rd(IDX_PB_CFG, 32'h0);
        rd(IDX_PC_CFGH, 32'h0);
        rd(IDX_PC_CFGL, 32'h0);
        `CHK(pb_oe, 3'h0, "reset enable")
        $display("reset test done");
        // Every first port mode, mixed pins included
        pb_src_en <= 3'h0;
        wr(IDX_PB_DATA, 8'h01);
        for (int k = 0; k < 6; k++) begin
            wr(IDX_PB_CFG, tb_cfg[k]);
            `CHK(pb_oe, tb_oe[k], "pb enable")
            `CHK(pb_out, tb_out[k], "pb value")
            `CHK(pb_pull_up, tb_pu[k], "pb pull-up")
            `CHK(pb_pull_down, tb_pd[k], "pb pull-down")
            rd(IDX_PB_CFG, {24'h0, tb_cfg[k]});
        end
        wr(IDX_PB_CFG, 8'h2A);
        rd(IDX_PB_DATA, 32'h1);
        $display("first port test done");
        // Second port push-pull, inputs with pull-up, alternates
        wr(IDX_PC_CFGL, 8'hAA);
        wr(IDX_PC_CFGH, 8'hEA);
        rd(IDX_PC_CFGH, 32'h2A);
        wr(IDX_PC_DATA, 8'h55);
        `CHK(pc_oe, 7'h7F, "pc enable")
        `CHK(pc_out, 7'h55, "pc value")
        wr(IDX_PC_CFGL, 8'h00);
        wr(IDX_PC_CFGH, 8'h00);
        wr(IDX_PC_PULL, 8'h7F);
        `CHK(pc_pull_up, 7'h7F, "pc pull-up")
        @(posedge pclk);
        pc_src <= 7'h33;
        rd(IDX_PC_DATA, 32'h33);
        wr(IDX_PC_CFGL, 8'hFF);
        wr(IDX_PC_CFGH, 8'h3F);
        `CHK(pc_analog_sel, PC_ANALOG, "analog select")
        `CHK(pc_oe, 7'h60, "alternate enable")
        `CHK(pc_out[6:5], 2'b01, "clock and timer out")
        @(posedge pclk);
        sys_clk_src <= 1'b0;
        timer_src <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        `CHK(pc_out[6:5], 2'b10, "alternate follows")
        $display("second port test done");
        // Unmapped place is refused and leaves the registers alone
        apb(10'h0ED, 1'b1, 8'hFF);
        `CHK(err_v, 1'b1, "unmapped write")
        apb(10'h0ED, 1'b0, 8'h00);
        `CHK({err_v, rd_v}, 33'h100000000, "unmapped read")
        rd(IDX_PB_CFG, 32'h2A);
        $display("unmapped test done");
        // Boot options take the low pins and the reset pin
        pb_src_en <= 3'h4;
        pb_src <= 3'h0;
        do_reset(1'b1, 1'b1);
        `CHK({osc_pins_sel, ext_reset_sel}, 2'b11, "options")
        wr(IDX_PB_CFG, 8'h2A);
        `CHK(pb_oe, 3'h0, "option pins driven")
        `CHK(pb_pull_up, 3'h4, "reset pin pull")
        `CHK(ext_reset_n, 1'b0, "reset pin low")
        rd(IDX_PB_DATA, 32'h0);
        pb_src <= 3'h4;
        repeat (2) @(posedge pclk);
        `CHK(ext_reset_n, 1'b1, "reset pin high")
        $display("boot option test done");
        print_verdict();
    end
endmodule
